/* File: logic/gpdir_pkg.sv */
// Purpose: Shared constants and types for the GPIO direction and pin sharing block
// Assumes: AHB-Lite word registers, byte address = 4 * register index
// Notes:   Pin vector order is P0.0, P1.0..P1.6, P5.0..P5.7 (bits 0..15)
package gpdir_pkg;

   // Register indices (byte address is four times the index)
   localparam logic [7:0] IDX_P0_DIR  = 8'hB8;
   localparam logic [7:0] IDX_P1_DIR  = 8'hC1;
   localparam logic [7:0] IDX_P5_DIR  = 8'hC5;
   localparam logic [7:0] IDX_P0_DATA = 8'hD0;
   localparam logic [7:0] IDX_P1_DATA = 8'hD1;
   localparam logic [7:0] IDX_P5_DATA = 8'hD5;
   localparam logic [7:0] IDX_BIT_OP  = 8'hF0;
   localparam logic [7:0] IDX_CONFIG  = 8'hF1;

   // Implemented bits of each port
   localparam logic [7:0] MASK_P0 = 8'h01;
   localparam logic [7:0] MASK_P1 = 8'h5F;
   localparam logic [7:0] MASK_P5 = 8'hFF;

   // Values after reset
   localparam logic [7:0] DIR_RESET    = 8'h00;
   localparam logic [7:0] DATA_RESET   = 8'h00;
   localparam logic [3:0] CONFIG_RESET = 4'h0;

   // Pin positions in the 16-bit pin vector
   localparam int PIN_COUNT   = 16;
   localparam int PIN_OSC_OUT = 5;
   localparam int PIN_RST     = 6;
   localparam int PIN_OSC_IN  = 7;
   localparam int PIN_BZ      = 12;

   // Bit operation register fields
   localparam int BITOP_NUM_LSB = 0;
   localparam int BITOP_TGT_LSB = 3;
   localparam int BITOP_VAL_BIT = 8;
   localparam logic [1:0] TGT_P0 = 2'h0;
   localparam logic [1:0] TGT_P1 = 2'h1;
   localparam logic [1:0] TGT_P5 = 2'h2;

   // Configuration register fields
   localparam int CFG_RST_BIT  = 0;
   localparam int CFG_HCLK_LSB = 1;
   localparam logic [2:0] HCLK_IHRC     = 3'h0;
   localparam logic [2:0] HCLK_INTERNAL_RC_WITH_RTC = 3'h1;
   localparam logic [2:0] HCLK_RC       = 3'h2;
   localparam logic [2:0] HCLK_32K      = 3'h3;
   localparam logic [2:0] HCLK_4M       = 3'h4;
   localparam logic [2:0] HCLK_12M      = 3'h5;

   // Bus transfer codes
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   typedef enum logic [1:0]
   {
      GPDIR_IDLE  = 2'b00,
      GPDIR_RWAIT = 2'b01,
      GPDIR_RDATA = 2'b11,
      GPDIR_WRITE = 2'b10
   } gpdir_bus_state_t;

endpackage

/* File: logic/gpdir_sync.sv */
// Purpose: Two-stage synchroniser for the pin inputs
// Assumes: Inputs are asynchronous to i_mclk
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module gpdir_sync
   import gpdir_pkg::*;
(
   // Clock and reset
   input  wire logic                 i_mclk,
   input  wire logic                 i_rst_n,
   // Data
   input  wire logic [PIN_COUNT-1:0] i_async,
   output logic      [PIN_COUNT-1:0] o_sync
);

   logic [PIN_COUNT-1:0] meta_reg;
   logic [PIN_COUNT-1:0] sync_reg;

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
      end
      else
      begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end

   assign o_sync = sync_reg;

endmodule
`default_nettype wire

/* File: logic/gpdir_port.sv */
// Purpose: Sixteen-pin GPIO port with direction registers and pin sharing
// Assumes: AHB-Lite slave, word transfers, single 125 MHz clock
// Notes:   Reads take one wait state so read data comes from a flip-flop
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Sixteen GPIO pins, many shared with analog or special functions.
// - Direction bit 0 makes a pin input, 1 makes it output.
// - Direction registers for ports 0, 1, 5; implemented bits reset to input.
// - Single-bit set and clear of a direction bit leaves other bits alone.
// - Port 1 pin 5 is input only; its direction bit does nothing.
// - Port 1 pin 5 is the external reset input when the option selects it.
// - Port 1 pin 6 is oscillator input for RTC, RC, 32K, 4M, 12M sources.
// - Port 1 pin 4 is oscillator output for RTC, 32K, 4M, 12M, not RC.
// - Port 5 pin 4 carries buzzer or PWM when timer and either output enabled.
module gpdir_port
   import gpdir_pkg::*;
(
   // Clock and reset
   input  wire logic                 i_mclk,
   input  wire logic                 i_rst_n,
   // AHB-Lite slave
   input  wire logic                 i_hsel,
   input  wire logic [31:0]          i_haddr,
   input  wire logic [1:0]           i_htrans,
   input  wire logic                 i_hwrite,
   input  wire logic [2:0]           i_hsize,
   input  wire logic [31:0]          i_hwdata,
   input  wire logic                 i_hready,
   output logic                      o_hreadyout,
   output logic                      o_hresp,
   output logic      [31:0]          o_hrdata,
   // Timer controls
   input  wire logic                 i_timer_counter_enable,
   input  wire logic                 i_timer_buzzer_out_enable,
   input  wire logic                 i_timer_pwm_out_enable,
   input  wire logic                 i_timer_buzzer_pwm_out,
   // Pins
   input  wire logic [PIN_COUNT-1:0] i_pin_in,
   output logic      [PIN_COUNT-1:0] o_pin_out,
   output logic      [PIN_COUNT-1:0] o_pin_oe,
   // Shared functions
   output logic                      o_ext_reset_req,
   output logic                      o_oscillator_in_sel,
   output logic                      o_oscillator_out_sel
);

   // Implemented-bit mask of a port selected by its bit-op target code
   function automatic logic [7:0] tgt_mask(input logic [1:0] tgt);
      logic [7:0] m;
      m = 8'h00;
      case (tgt)
         TGT_P0:  m = MASK_P0;
         TGT_P1:  m = MASK_P1;
         TGT_P5:  m = MASK_P5;
         default: m = 8'h00;
      endcase
      return m;
   endfunction

   // Sets or clears one bit of a port image, implemented bits only
   function automatic logic [7:0] bit_update(input logic [7:0] old_val,
                                             input logic [1:0] tgt,
                                             input logic [2:0] num,
                                             input logic       val);
      logic [7:0] r;
      r = old_val;
      r[num] = val;
      return r & tgt_mask(tgt);
   endfunction

   // Bus state
   gpdir_bus_state_t state_reg;
   gpdir_bus_state_t state_next;
   logic [7:0]       idx_reg;
   logic [7:0]       idx_next;
   logic             hit_reg;
   logic             hit_next;
   logic [31:0]      rdata_reg;
   logic [31:0]      rdata_next;

   // Register state
   logic [7:0] port0_direction;
   logic [7:0] port0_direction_next;
   logic [7:0] port1_direction;
   logic [7:0] port1_direction_next;
   logic [7:0] port5_direction;
   logic [7:0] port5_direction_next;
   logic [7:0] p0_data_reg;
   logic [7:0] p0_data_next;
   logic [7:0] p1_data_reg;
   logic [7:0] p1_data_next;
   logic [7:0] p5_data_reg;
   logic [7:0] p5_data_next;
   logic [3:0] config_reg;
   logic [3:0] config_next;

   // Pin state
   logic [PIN_COUNT-1:0] pin_out_reg;
   logic [PIN_COUNT-1:0] pin_out_next;
   logic [PIN_COUNT-1:0] pin_oe_reg;
   logic [PIN_COUNT-1:0] pin_oe_next;
   logic                 ext_rst_reg;
   logic                 ext_rst_next;
   logic                 osc_in_reg;
   logic                 osc_in_next;
   logic                 osc_out_reg;
   logic                 osc_out_next;

   // Combinational helpers
   logic                 accept;
   logic                 wr_go;
   logic [PIN_COUNT-1:0] pin_sync;
   logic [PIN_COUNT-1:0] dir_all;
   logic [PIN_COUNT-1:0] lat_all;
   logic [PIN_COUNT-1:0] rd_all;
   logic [PIN_COUNT-1:0] ovr_en;
   logic [PIN_COUNT-1:0] ovr_oe;
   logic [PIN_COUNT-1:0] ovr_out;
   logic                 rst_opt;
   logic [2:0]           hclk_sel;
   logic                 osc_in_use;
   logic                 osc_out_use;
   logic                 bz_use;
   logic [1:0]           bop_tgt;
   logic [2:0]           bop_num;
   logic                 bop_val;

   gpdir_sync u_sync
   (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_async (i_pin_in),
      .o_sync  (pin_sync)
   );

   // Bus slave
   assign accept = i_hsel & i_htrans[1] & i_hready;
   assign wr_go  = (state_reg == GPDIR_WRITE) & hit_reg;

   always_comb
   begin
      state_next = state_reg;
      idx_next   = idx_reg;
      hit_next   = hit_reg;
      rdata_next = rdata_reg;
      case (state_reg)
         GPDIR_RWAIT:
         begin
            // Read value is captured here, after any earlier write has landed
            rdata_next = 32'h0000_0000;
            if (hit_reg)
            begin
               case (idx_reg)
                  IDX_P0_DIR:  rdata_next[7:0] = port0_direction;
                  IDX_P1_DIR:  rdata_next[7:0] = port1_direction;
                  IDX_P5_DIR:  rdata_next[7:0] = port5_direction;
                  IDX_P0_DATA: rdata_next[7:0] = {7'h00, rd_all[0]};
                  IDX_P1_DATA: rdata_next[7:0] = {1'b0, rd_all[7:1]};
                  IDX_P5_DATA: rdata_next[7:0] = rd_all[15:8];
                  IDX_CONFIG:  rdata_next[3:0] = config_reg;
                  default:     rdata_next = 32'h0000_0000;
               endcase
            end
            state_next = GPDIR_RDATA;
         end
         default:
         begin
            if (accept)
            begin
               idx_next   = i_haddr[9:2];
               hit_next   = (i_haddr[31:10] == 22'h00_0000) & (i_haddr[1:0] == 2'h0)
                            & (i_hsize == HSIZE_WORD);
               state_next = i_hwrite ? GPDIR_WRITE : GPDIR_RWAIT;
            end
            else
            begin
               state_next = GPDIR_IDLE;
            end
            if (state_reg == GPDIR_IDLE)
            begin
               rdata_next = 32'h0000_0000;
            end
         end
      endcase
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         state_reg <= GPDIR_IDLE;
         idx_reg   <= 8'h00;
         hit_reg   <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         state_reg <= state_next;
         idx_reg   <= idx_next;
         hit_reg   <= hit_next;
         rdata_reg <= rdata_next;
      end
   end

   assign o_hreadyout = (state_reg != GPDIR_RWAIT);
   assign o_hresp     = 1'b0;
   assign o_hrdata    = rdata_reg;

   // Register file
   assign bop_num = i_hwdata[BITOP_NUM_LSB +: 3];
   assign bop_tgt = i_hwdata[BITOP_TGT_LSB +: 2];
   assign bop_val = i_hwdata[BITOP_VAL_BIT];

   always_comb
   begin
      port0_direction_next = port0_direction;
      port1_direction_next = port1_direction;
      port5_direction_next = port5_direction;
      p0_data_next         = p0_data_reg;
      p1_data_next         = p1_data_reg;
      p5_data_next         = p5_data_reg;
      config_next          = config_reg;
      if (wr_go)
      begin
         case (idx_reg)
            // Unimplemented bits, P1.5 among them, never store
            IDX_P0_DIR:  port0_direction_next = i_hwdata[7:0] & tgt_mask(TGT_P0);
            IDX_P1_DIR:  port1_direction_next = i_hwdata[7:0] & tgt_mask(TGT_P1);
            IDX_P5_DIR:  port5_direction_next = i_hwdata[7:0] & tgt_mask(TGT_P5);
            IDX_P0_DATA: p0_data_next         = i_hwdata[7:0] & MASK_P0;
            IDX_P1_DATA: p1_data_next         = i_hwdata[7:0] & MASK_P1;
            IDX_P5_DATA: p5_data_next         = i_hwdata[7:0] & MASK_P5;
            IDX_CONFIG:  config_next          = i_hwdata[3:0];
            IDX_BIT_OP:
            begin
               case (bop_tgt)
                  TGT_P0:
                     port0_direction_next = bit_update(port0_direction, bop_tgt,
                                                       bop_num, bop_val);
                  TGT_P1:
                     port1_direction_next = bit_update(port1_direction, bop_tgt,
                                                       bop_num, bop_val);
                  TGT_P5:
                     port5_direction_next = bit_update(port5_direction, bop_tgt,
                                                       bop_num, bop_val);
                  default:
                     port5_direction_next = port5_direction;
               endcase
            end
            default:
               config_next = config_reg;
         endcase
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         port0_direction <= DIR_RESET;
         port1_direction <= DIR_RESET;
         port5_direction <= DIR_RESET;
         p0_data_reg     <= DATA_RESET;
         p1_data_reg     <= DATA_RESET;
         p5_data_reg     <= DATA_RESET;
         config_reg      <= CONFIG_RESET;
      end
      else
      begin
         port0_direction <= port0_direction_next;
         port1_direction <= port1_direction_next;
         port5_direction <= port5_direction_next;
         p0_data_reg     <= p0_data_next;
         p1_data_reg     <= p1_data_next;
         p5_data_reg     <= p5_data_next;
         config_reg      <= config_next;
      end
   end

   // Sixteen-pin images of direction and latch
   assign dir_all = {port5_direction, port1_direction[6:0], port0_direction[0]};
   assign lat_all = {p5_data_reg, p1_data_reg[6:0], p0_data_reg[0]};

   // Shared-function selection
   assign rst_opt  = config_reg[CFG_RST_BIT];
   assign hclk_sel = config_reg[CFG_HCLK_LSB +: 3];

   always_comb
   begin
      osc_in_use  = 1'b0;
      osc_out_use = 1'b0;
      case (hclk_sel)
         HCLK_INTERNAL_RC_WITH_RTC, HCLK_32K, HCLK_4M, HCLK_12M:
         begin
            osc_in_use  = 1'b1;
            osc_out_use = 1'b1;
         end
         HCLK_RC:
         begin
            // RC uses only the input pin; the output pin stays general purpose
            osc_in_use  = 1'b1;
            osc_out_use = 1'b0;
         end
         default:
         begin
            osc_in_use  = 1'b0;
            osc_out_use = 1'b0;
         end
      endcase
   end

   assign bz_use = i_timer_counter_enable
                   & (i_timer_buzzer_out_enable | i_timer_pwm_out_enable);

   always_comb
   begin
      ovr_en  = '0;
      ovr_oe  = '0;
      ovr_out = '0;
      // Input-only pin is never driven, whatever its direction bit holds
      ovr_en[PIN_RST]      = 1'b1;
      // Oscillator pins are analog; digital drive must be off
      ovr_en[PIN_OSC_IN]   = osc_in_use;
      ovr_en[PIN_OSC_OUT]  = osc_out_use;
      ovr_en[PIN_BZ]       = bz_use;
      ovr_oe[PIN_BZ]       = 1'b1;
      ovr_out[PIN_BZ]      = i_timer_buzzer_pwm_out;
   end

   // Read image: latch for outputs, sampled pin for inputs; P1.5 reads 1 while the reset option is set
   always_comb
   begin
      rd_all = (dir_all & lat_all) | (~dir_all & pin_sync);
      rd_all[PIN_RST] = rst_opt ? 1'b1 : pin_sync[PIN_RST];
   end

   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi = gi + 1)
      begin : g_pin
         assign pin_oe_next[gi]  = ovr_en[gi] ? ovr_oe[gi] : dir_all[gi];
         assign pin_out_next[gi] = ovr_en[gi] ? ovr_out[gi]
                                              : (dir_all[gi] & lat_all[gi]);
      end
   endgenerate

   always_comb
   begin
      // Reset pin is active low on the board
      ext_rst_next = rst_opt & ~pin_sync[PIN_RST];
      osc_in_next  = osc_in_use;
      osc_out_next = osc_out_use;
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         pin_out_reg <= '0;
         pin_oe_reg  <= '0;
         ext_rst_reg <= 1'b0;
         osc_in_reg  <= 1'b0;
         osc_out_reg <= 1'b0;
      end
      else
      begin
         pin_out_reg <= pin_out_next;
         pin_oe_reg  <= pin_oe_next;
         ext_rst_reg <= ext_rst_next;
         osc_in_reg  <= osc_in_next;
         osc_out_reg <= osc_out_next;
      end
   end

   assign o_pin_out            = pin_out_reg;
   assign o_pin_oe             = pin_oe_reg;
   assign o_ext_reset_req      = ext_rst_reg;
   assign o_oscillator_in_sel  = osc_in_reg;
   assign o_oscillator_out_sel = osc_out_reg;

endmodule
`default_nettype wire

/* File: dv/gpdir_board_model.sv */
// Purpose: Board side of the sixteen port pins
// Assumes: No pull resistors modelled on the board
// Notes:   An undriven pin shows the bench pattern, changed each pass of the direction and clock source loops
`timescale 1ns/100ps
`default_nettype none
module gpdir_board_model
(
   // From the port
   input  wire logic [15:0] i_pin_out,
   input  wire logic [15:0] i_pin_oe,
   // Board pattern
   input  wire logic [15:0] i_float,
   output logic      [15:0] o_level
);
   // A driven pin wins over the board
   assign o_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_float);
endmodule
`default_nettype wire

/* File: dv/gpdir_port_checker.sv */
// Purpose: Port-level checks of the GPIO direction block
// Assumes: Single clock, synchronous active-low reset
// Notes:   Bound to every gpdir_port instance
`timescale 1ns/100ps
`default_nettype none
module gpdir_port_checker
   import gpdir_pkg::*;
(
   // Clock and reset
   input  wire logic                 i_mclk,
   input  wire logic                 i_rst_n,
   // Bus
   input  wire logic                 i_hsel,
   input  wire logic [1:0]           i_htrans,
   input  wire logic                 i_hwrite,
   input  wire logic                 i_hready,
   input  wire logic                 o_hreadyout,
   input  wire logic                 o_hresp,
   // Timer and pins
   input  wire logic                 i_timer_counter_enable,
   input  wire logic                 i_timer_buzzer_out_enable,
   input  wire logic                 i_timer_pwm_out_enable,
   input  wire logic                 i_timer_buzzer_pwm_out,
   input  wire logic [PIN_COUNT-1:0] o_pin_out,
   input  wire logic [PIN_COUNT-1:0] o_pin_oe,
   input  wire logic                 o_oscillator_in_sel,
   input  wire logic                 o_oscillator_out_sel
);
   logic take;
   logic bz_on;
   assign take  = i_hsel && i_htrans[1] && i_hready;
   assign bz_on = i_timer_counter_enable && (i_timer_buzzer_out_enable || i_timer_pwm_out_enable);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);
   read_wait_a: assert property (take && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
      else $error("read did not take exactly one wait cycle");
   write_nowait_a: assert property (take && i_hwrite |=> o_hreadyout)
      else $error("write data phase stalled");
   wait_cause_a: assert property (!o_hreadyout |-> $past(take && !i_hwrite))
      else $error("wait state without a read");
   resp_okay_a: assert property (o_hresp == 1'b0)
      else $error("error response seen");
   rst_pin_input_a: assert property (o_pin_oe[PIN_RST] == 1'b0)
      else $error("input-only pin driven");
   buzzer_drive_a: assert property (bz_on |=> o_pin_oe[PIN_BZ]
      && o_pin_out[PIN_BZ] == $past(i_timer_buzzer_pwm_out))
      else $error("buzzer pin not carrying timer output");
   osc_in_free_a: assert property (o_oscillator_in_sel
      && $past(o_oscillator_in_sel) |-> !o_pin_oe[PIN_OSC_IN])
      else $error("oscillator input pin driven");
   osc_out_free_a: assert property (o_oscillator_out_sel
      && $past(o_oscillator_out_sel) |-> !o_pin_oe[PIN_OSC_OUT])
      else $error("oscillator output pin driven");
   float_quiet_a: assert property ((o_pin_out & ~o_pin_oe) == 16'h0000)
      else $error("undriven pin has nonzero value");
endmodule
bind gpdir_port gpdir_port_checker u_chk (.*);
`default_nettype wire

/* File: dv/test_gpdir_port.sv */
// Purpose: Self-checking bench of the GPIO direction block
// Assumes: One slave on the bus, so hready is the slave's own hreadyout
// Notes:   Reads queue their expected byte; a monitor compares on completion
`timescale 1ns/100ps
`default_nettype none
module test_gpdir_port
   import gpdir_pkg::*;
;
   logic        i_mclk = 1'b0;
   logic        i_rst_n = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = HSIZE_WORD;
   logic [31:0] hwdata = 32'h0;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        ten = 1'b0;
   logic        tbz = 1'b0;
   logic        tpwm = 1'b0;
   logic        tbuz = 1'b0;
   logic [15:0] board = 16'h0;
   logic [15:0] pin_in;
   logic [15:0] pin_out;
   logic [15:0] pin_oe;
   logic        ext_rst;
   logic        osc_in;
   logic        osc_out;
   logic [7:0]  dir [3] = '{8'h00, 8'h00, 8'h00};
   logic [7:0]  lat [3] = '{8'h00, 8'h00, 8'h00};
   logic [3:0]  cfg = 4'h0;
   logic [15:0] eoe;
   logic [15:0] eov;
   logic [7:0]  exq [$];
   logic        rd_pend = 1'b0;
   int          err_count = 0;
   int          cmp_count = 0;
   localparam logic [7:0] DIRI [3] = '{IDX_P0_DIR, IDX_P1_DIR, IDX_P5_DIR};
   localparam logic [7:0] DATI [3] = '{IDX_P0_DATA, IDX_P1_DATA, IDX_P5_DATA};
   localparam logic [7:0] MSK [3] = '{MASK_P0, MASK_P1, MASK_P5};
   localparam logic [7:0] DMSK [3] = '{8'h01, 8'h7F, 8'hFF};

   always #4 i_mclk = ~i_mclk;

   gpdir_port uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
      .i_hready(hreadyout), .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata),
      .i_timer_counter_enable(ten), .i_timer_buzzer_out_enable(tbz),
      .i_timer_pwm_out_enable(tpwm), .i_timer_buzzer_pwm_out(tbuz), .i_pin_in(pin_in),
      .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_ext_reset_req(ext_rst),
      .o_oscillator_in_sel(osc_in), .o_oscillator_out_sel(osc_out));
   gpdir_board_model u_board (.i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_float(board),
      .o_level(pin_in));

   task automatic final_report();
      if (exq.size() != 0)
      begin
         err_count++;
         $display("wrong value at %0t: reads left unanswered", $time);
      end
      $display("errors %0d comparisons %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic wait_rdy();
      int n;
      n = 0;
      do
      begin
         @(posedge i_mclk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1)
      begin
         err_count++;
         $display("wrong value at %0t: bus wait timed out", $time);
         final_report();
      end
   endtask

   // One single word transfer; a read queues the byte it should return
   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                      input logic [7:0] exp);
      @(posedge i_mclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {22'h0, idx, 2'h0};
      if (!w)
         exq.push_back(exp);
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
   endtask

   function automatic logic [7:0] sl(input logic [15:0] v, input int k);
      return (k == 0) ? {7'h0, v[0]} : (k == 1) ? {1'b0, v[7:1]} : v[15:8];
   endfunction

   // Four edges cover the register stage and the two synchroniser flops
   task automatic chk_pins();
      logic oi;
      logic oo;
      repeat (4) @(negedge i_mclk);
      oi = cfg[3:1] >= 3'h1 && cfg[3:1] <= 3'h5;
      oo = oi && cfg[3:1] != HCLK_RC;
      eoe = {dir[2], dir[1][6:0] & 7'h5F, dir[0][0]};
      eov = {lat[2], lat[1][6:0], lat[0][0]} & eoe;
      eoe[7] = eoe[7] & !oi;
      eov[7] = eov[7] & !oi;
      eoe[5] = eoe[5] & !oo;
      eov[5] = eov[5] & !oo;
      if (ten && (tbz || tpwm))
      begin
         eoe[12] = 1'b1;
         eov[12] = tbuz;
      end
      chk(pin_oe, eoe);
      chk(pin_out, eov);
      chk(osc_in, oi);
      chk(osc_out, oo);
      chk(ext_rst, cfg[0] && !board[6]);
   endtask

   task automatic rd_data(input int k);
      logic [7:0] e;
      e = sl((eov & eoe) | (board & ~eoe), k) & DMSK[k];
      if (k == 1 && cfg[0])
         e[5] = 1'b1;
      bus(1'b0, DATI[k], 32'h0, e);
   endtask

   always @(posedge i_mclk)
   begin
      if (rd_pend && hreadyout === 1'b1)
      begin
         rd_pend <= 1'b0;
         if (exq.size() == 0)
         begin
            err_count++;
            $display("wrong value at %0t: read data with no expected value", $time);
         end
         else
            chk(hrdata, {24'h0, exq.pop_front()});
      end
      if (hsel && htrans[1] && hreadyout && !hwrite)
         rd_pend <= 1'b1;
   end

   initial
   begin
      logic [31:0] r;
      logic [1:0]  t;
      logic [2:0]  b;
      void'($urandom(41));
      repeat (3) @(posedge i_mclk);
      chk(hreadyout, 1'b1);
      i_rst_n <= 1'b1;
      chk_pins();
      for (int k = 0; k < 3; k++)
         bus(1'b0, DIRI[k], 32'h0, 8'h00);
      // Random direction and latch values, direction all ones first
      for (int i = 0; i < 6; i++)
      begin
         board <= 16'($urandom);
         for (int k = 0; k < 3; k++)
         begin
            r = (i == 0) ? 32'hFFFFFFFF : $urandom;
            bus(1'b1, DIRI[k], r, 8'h00);
            dir[k] = r[7:0] & MSK[k];
            r = $urandom;
            bus(1'b1, DATI[k], r, 8'h00);
            lat[k] = r[7:0];
         end
         chk_pins();
         for (int k = 0; k < 3; k++)
         begin
            bus(1'b0, DIRI[k], 32'h0, dir[k]);
            rd_data(k);
         end
      end
      // Single-bit set and clear, target 3 changes nothing
      for (int i = 0; i < 16; i++)
      begin
         r = $urandom;
         t = r[4:3];
         b = r[2:0];
         bus(1'b1, IDX_BIT_OP, {23'h0, r[8], 3'h0, t, b}, 8'h00);
         if (t != 2'h3)
            dir[t][b] = r[8] & MSK[t][b];
         for (int k = 0; k < 3; k++)
            bus(1'b0, DIRI[k], 32'h0, dir[k]);
      end
      bus(1'b1, IDX_BIT_OP, 32'h0000012D, 8'h00);
      bus(1'b0, IDX_BIT_OP, 32'h0, 8'h00);
      bus(1'b0, IDX_P1_DIR, 32'h0, dir[1]);
      chk_pins();
      bus(1'b1, IDX_P1_DIR, 32'h5F, 8'h00);
      dir[1] = 8'h5F;
      // Every clock source code with the reset option both ways
      for (int c = 0; c < 16; c++)
      begin
         board <= 16'($urandom);
         cfg = c[3:0];
         bus(1'b1, IDX_CONFIG, {28'h0, cfg}, 8'h00);
         bus(1'b0, IDX_CONFIG, 32'h0, {4'h0, cfg});
         chk_pins();
         if (c < 2)
            rd_data(1);
      end
      cfg = 4'h0;
      bus(1'b1, IDX_CONFIG, 32'h0, 8'h00);
      // Timer controls in every combination
      for (int m = 0; m < 16; m++)
      begin
         @(posedge i_mclk);
         {ten, tbz, tpwm, tbuz} <= m[3:0];
         chk_pins();
      end
      // Unmapped place and non-word size are refused
      bus(1'b1, 8'h10, 32'hFFFFFFFF, 8'h00);
      bus(1'b0, 8'h10, 32'h0, 8'h00);
      hsize <= 3'h0;
      bus(1'b1, IDX_P5_DIR, ~{24'h0, dir[2]}, 8'h00);
      bus(1'b0, IDX_P5_DIR, 32'h0, 8'h00);
      hsize <= HSIZE_WORD;
      bus(1'b0, IDX_P5_DIR, 32'h0, dir[2]);
      repeat (3) @(posedge i_mclk);
      final_report();
   end
endmodule
`default_nettype wire
